// ### verilog/cap_hdr_bank.sv
// Chosen here: the APB register port.
`timescale 1ns/10ps
//------------------------------------------------------------
// ARI and SR-IOV capability header bank, APB slave
//------------------------------------------------------------
// Contract
// - ARI header: ID 0x000E, version one
// - Attached VFs: pointer selects SR-IOV offset
// - PF0 at 8.0 GT/s: Secondary PCIe
// - PF0 slower with TPH: TPH offset
// - PF0 slower, ATS, no TPH: ATS
// - PFs one to three: TPH else ATS
// - Otherwise pointer reads zero
// - ARI control arbitration and reserved bits zero
// - ARI control next function, default one
// - SR-IOV header: ID 0x0010, version one
// - SR-IOV pointer uses same selection
// - Secondary PCIe only PF0 at gen3
module cap_hdr_bank #(
	parameter int LINK_GEN = 3,
	parameter bit HAS_TPH = 1'b0,
	parameter bit HAS_ATS = 1'b0,
	parameter int VF_COUNT = 0,
	parameter int PF_INDEX = 0,
	parameter logic [7:0] NEXT_FUNC = 8'h01
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pointer shown to the rest of the function
	output logic [11:0] next_cap_ptr
);
	import cap_hdr_pkg::*;

	//------------------------------------------------------------
	// Elaboration checks
	//------------------------------------------------------------
	generate
		// Build settings this logic can serve
		if (LINK_GEN < 1 || LINK_GEN > 3) begin : g_bad_gen
			$error("LINK_GEN must be 1, 2 or 3");
		end
		if (PF_INDEX < 0 || PF_INDEX > 3) begin : g_bad_pf
			$error("PF_INDEX must be 0 to 3");
		end
		if (VF_COUNT < 0 || VF_COUNT > 65535) begin : g_bad_vf
			$error("VF_COUNT must fit sixteen bits");
		end

		// Word layout: version below pointer, pointer inside the word
		if (VER_LSB + 4 > PTR_LSB || PTR_LSB + 12 > 32) begin : g_bad_hdr
			$error("Header field layout does not fit");
		end
		// Next function field must stay in the low half above bit 0
		if (NEXT_FN_LSB < 1 || NEXT_FN_LSB + 8 > 16) begin : g_bad_fn
			$error("Next function field layout does not fit");
		end
		// Status flag must sit above the pointer copy
		if (DROP_FLAG_BIT < 12 || DROP_FLAG_BIT > 31) begin : g_bad_stat
			$error("Status flag position does not fit");
		end
		// Control bits must be distinct and inside the strobed byte
		if (ERR_EN_BIT == DROP_CLR_BIT || ERR_EN_BIT > 7 || DROP_CLR_BIT > 7) begin : g_bad_ctrl
			$error("Control bit positions clash");
		end
		// Whole words only: offsets must be word aligned
		if (ARI_HDR_OFS[1:0] != 2'b00 || ARI_CTRL_OFS[1:0] != 2'b00 || SRIOV_HDR_OFS[1:0] != 2'b00 ||
			BANK_CTRL_OFS[1:0] != 2'b00 || BANK_STAT_OFS[1:0] != 2'b00) begin : g_bad_ofs
			$error("Register offsets must be word aligned");
		end
	endgenerate

	//------------------------------------------------------------
	// Build configuration and pointer selection
	//------------------------------------------------------------
	cap_cfg_t cfg;
	logic [11:0] ptr_q;

	// Fixed settings of this function
	always_comb begin
		cfg.link_gen = LINK_GEN[1:0];
		cfg.has_tph = HAS_TPH;
		cfg.has_ats = HAS_ATS;
		cfg.vf_count = VF_COUNT[15:0];
		cfg.pf_index = PF_INDEX[1:0];
	end

	// One selector feeds both headers
	next_cap_select u_select (
		.clock(clock),
		.rst_b(rst_b),
		.cfg(cfg),
		.ptr_q(ptr_q)
	);

	assign next_cap_ptr = ptr_q;

	//------------------------------------------------------------
	// Read-only words
	//------------------------------------------------------------
	logic [31:0] ari_hdr_word;
	logic [31:0] ari_ctrl_word;
	logic [31:0] sriov_hdr_word;
	logic [7:0] next_fn_q;

	// ARI header: ID, version, pointer
	always_comb begin
		ari_hdr_word = WORD_RST;
		ari_hdr_word[ID_LSB +: 16] = ARI_CAP_ID;
		ari_hdr_word[VER_LSB +: 4] = CAP_VERSION;
		ari_hdr_word[PTR_LSB +: 12] = ptr_q;
	end

	// ARI control: only the next function number is non-zero
	always_comb begin
		ari_ctrl_word = WORD_RST;
		ari_ctrl_word[NEXT_FN_LSB +: 8] = next_fn_q;
	end

	// SR-IOV header: version sits below the pointer
	always_comb begin
		sriov_hdr_word = WORD_RST;
		sriov_hdr_word[ID_LSB +: 16] = SRIOV_CAP_ID;
		sriov_hdr_word[VER_LSB +: 4] = CAP_VERSION;
		sriov_hdr_word[PTR_LSB +: 12] = ptr_q;
	end

	//------------------------------------------------------------
	// Next function number
	//------------------------------------------------------------
	logic [7:0] next_fn_d;

	// Loaded from the build setting after reset, never written
	always_comb begin
		next_fn_d = NEXT_FUNC;
	end

	// Next function register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			next_fn_q <= NEXT_FN_RST;
		end else begin
			next_fn_q <= next_fn_d;
		end
	end

	//------------------------------------------------------------
	// APB phase decode
	//------------------------------------------------------------
	logic setup_phase;
	logic access_phase;
	logic hit_ari_hdr;
	logic hit_ari_ctrl;
	logic hit_sriov_hdr;
	logic hit_bank_ctrl;
	logic hit_bank_stat;
	logic hit_ro_hdr;
	logic hit_any;

	// Phases of a transfer
	always_comb begin
		setup_phase = psel & ~penable;
		access_phase = psel & penable;
	end

	// Address decode on whole aligned words
	always_comb begin
		hit_ari_hdr = (paddr == ARI_HDR_OFS);
		hit_ari_ctrl = (paddr == ARI_CTRL_OFS);
		hit_sriov_hdr = (paddr == SRIOV_HDR_OFS);
		hit_bank_ctrl = (paddr == BANK_CTRL_OFS);
		hit_bank_stat = (paddr == BANK_STAT_OFS);
		hit_ro_hdr = hit_ari_hdr | hit_ari_ctrl | hit_sriov_hdr;
		hit_any = hit_ro_hdr | hit_bank_ctrl | hit_bank_stat;
	end

	//------------------------------------------------------------
	// Bank control and status
	//------------------------------------------------------------
	logic err_en_q;
	logic err_en_d;
	logic drop_q;
	logic drop_d;
	logic ctrl_wr;
	logic ro_wr;
	logic drop_clr;

	// Write strobes, taken at the access edge only
	always_comb begin
		ctrl_wr = access_phase & pwrite & hit_bank_ctrl & pstrb[0];
		ro_wr = access_phase & pwrite & hit_ro_hdr;
		drop_clr = ctrl_wr & pwdata[DROP_CLR_BIT];
	end

	// Error enable is kept, dropped-write flag is sticky
	always_comb begin
		err_en_d = err_en_q;
		if (ctrl_wr) begin
			err_en_d = pwdata[ERR_EN_BIT];
		end
		drop_d = drop_q;
		if (drop_clr) begin
			drop_d = 1'b0;
		end
		if (ro_wr) begin
			drop_d = 1'b1; // A new drop beats a clear
		end
	end

	// Control and status registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			err_en_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			err_en_q <= err_en_d;
			drop_q <= drop_d;
		end
	end

	//------------------------------------------------------------
	// Read-back words of the bank's own registers
	//------------------------------------------------------------
	logic [31:0] bank_ctrl_word;
	logic [31:0] bank_stat_word;

	// Control read-back: error enable only, clear bit reads zero
	always_comb begin
		bank_ctrl_word = WORD_RST;
		bank_ctrl_word[ERR_EN_BIT] = err_en_q;
	end

	// Status: pointer copy in the low bits, sticky dropped-write flag
	always_comb begin
		bank_stat_word = WORD_RST;
		bank_stat_word[ID_LSB +: 12] = ptr_q;
		bank_stat_word[DROP_FLAG_BIT] = drop_q;
	end

	//------------------------------------------------------------
	// Read data and error, prepared in the setup cycle
	//------------------------------------------------------------
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic err_q;
	logic err_d;

	// Read mux; writes to header words are accepted and dropped
	always_comb begin
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup_phase) begin
			rdata_d = WORD_RST;
			err_d = err_en_q & ~hit_any;
			if (!pwrite) begin
				if (hit_ari_hdr) begin
					rdata_d = ari_hdr_word;
				end
				if (hit_ari_ctrl) begin
					rdata_d = ari_ctrl_word;
				end
				if (hit_sriov_hdr) begin
					rdata_d = sriov_hdr_word;
				end
				if (hit_bank_ctrl) begin
					rdata_d = bank_ctrl_word;
				end
				if (hit_bank_stat) begin
					rdata_d = bank_stat_word;
				end
			end
		end
	end

	// Read data and error registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= WORD_RST;
			err_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	//------------------------------------------------------------
	// Answer: no wait states
	//------------------------------------------------------------
	// Ready in the first access cycle, error only while selected
	always_comb begin
		pready = access_phase;
		pslverr = access_phase & err_q;
		prdata = rdata_q;
	end

endmodule : cap_hdr_bank

// ### verilog/cap_hdr_pkg.sv
//------------------------------------------------------------
// Shared constants and types for the capability header bank
//------------------------------------------------------------
package cap_hdr_pkg;

	// Register byte offsets
	localparam logic [11:0] ARI_HDR_OFS = 12'h160;
	localparam logic [11:0] ARI_CTRL_OFS = 12'h164;
	localparam logic [11:0] BANK_CTRL_OFS = 12'h170;
	localparam logic [11:0] BANK_STAT_OFS = 12'h174;
	localparam logic [11:0] SRIOV_HDR_OFS = 12'h200;

	// Capability identifiers and version
	localparam logic [15:0] ARI_CAP_ID = 16'h000e;
	localparam logic [15:0] SRIOV_CAP_ID = 16'h0010;
	localparam logic [3:0] CAP_VERSION = 4'h1;

	// Field positions inside the header, control and status words
	localparam int ID_LSB = 0;
	localparam int VER_LSB = 16;
	localparam int PTR_LSB = 20;
	localparam int NEXT_FN_LSB = 8;
	localparam int DROP_FLAG_BIT = 16;
	localparam int ERR_EN_BIT = 0;
	localparam int DROP_CLR_BIT = 1;

	// Next-capability pointer targets
	localparam logic [11:0] PTR_SRIOV = 12'h200;
	localparam logic [11:0] PTR_SEC_PCIE = 12'h280;
	localparam logic [11:0] PTR_TPH = 12'h300;
	localparam logic [11:0] PTR_ATS = 12'h3c0;
	localparam logic [11:0] PTR_END = 12'h000;

	// Reset values
	localparam logic [7:0] NEXT_FN_RST = 8'h01;
	localparam logic [11:0] PTR_RST = 12'h000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	// Link speed generations (1 = 2.5 GT/s, 2 = 5.0 GT/s, 3 = 8.0 GT/s)
	localparam logic [1:0] LINK_GEN1 = 2'd1;
	localparam logic [1:0] LINK_GEN3 = 2'd3;
	localparam logic [1:0] PF_ZERO = 2'd0;

	// Build-time configuration of one physical function
	typedef struct packed {
		logic [1:0] link_gen;
		logic has_tph;
		logic has_ats;
		logic [15:0] vf_count;
		logic [1:0] pf_index;
	} cap_cfg_t;

endpackage : cap_hdr_pkg

// ### verilog/next_cap_select.sv
`timescale 1ns/10ps
//------------------------------------------------------------
// Next-capability pointer selection from build settings
//------------------------------------------------------------
module next_cap_select (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Function configuration
	input wire cap_hdr_pkg::cap_cfg_t cfg,
	// Selected pointer
	output logic [11:0] ptr_q
);
	import cap_hdr_pkg::*;

	logic [11:0] ptr_d;

	// Priority walk over the configuration
	always_comb begin
		ptr_d = PTR_END;
		if (cfg.vf_count != 16'h0000) begin
			ptr_d = PTR_SRIOV;
		end else if (cfg.pf_index == PF_ZERO) begin
			if (cfg.link_gen == LINK_GEN3) begin
				ptr_d = PTR_SEC_PCIE;
			end else if (cfg.has_tph) begin
				ptr_d = PTR_TPH;
			end else if (cfg.has_ats) begin
				ptr_d = PTR_ATS;
			end
		end else begin
			if (cfg.has_tph) begin
				ptr_d = PTR_TPH;
			end else if (cfg.has_ats) begin
				ptr_d = PTR_ATS;
			end
		end
	end

	// Pointer register, settles one edge after reset release
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ptr_q <= PTR_RST;
		end else begin
			ptr_q <= ptr_d;
		end
	end

endmodule : next_cap_select

// ### bench/cap_hdr_checker.sv
`timescale 1ns/10ps
//--------
// Header bank checker
//--------
module cap_hdr_checker
	import cap_hdr_pkg::*;
#(
	parameter int LINK_GEN = 3,
	parameter bit HAS_TPH = 1'b0,
	parameter bit HAS_ATS = 1'b0,
	parameter int VF_COUNT = 0,
	parameter int PF_INDEX = 0,
	parameter logic [7:0] NEXT_FUNC = 8'h01
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// APB
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [11:0] next_cap_ptr
);
	// Pointer this build should select
	localparam logic [11:0] EXP = VF_COUNT != 0 ? PTR_SRIOV : PF_INDEX == 0 ?
		(LINK_GEN == 3 ? PTR_SEC_PCIE : HAS_TPH ? PTR_TPH : HAS_ATS ? PTR_ATS : PTR_END) :
		(HAS_TPH ? PTR_TPH : HAS_ATS ? PTR_ATS : PTR_END);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Read setup followed by its access cycle
	sequence s_rd(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a ##1 psel && penable;
	endsequence
	property p_ari_id; s_rd(ARI_HDR_OFS) |-> prdata[19:0] == {CAP_VERSION, ARI_CAP_ID}; endproperty
	a_ari_id: assert property (p_ari_id) else $error("ari id wrong");
	property p_ari_ptr; s_rd(ARI_HDR_OFS) |-> prdata[31:20] == EXP; endproperty
	a_ari_ptr: assert property (p_ari_ptr) else $error("ari pointer wrong");
	property p_ctl_zero; s_rd(ARI_CTRL_OFS) |-> prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00; endproperty
	a_ctl_zero: assert property (p_ctl_zero) else $error("control zero bits set");
	property p_ctl_fn; s_rd(ARI_CTRL_OFS) |-> prdata[15:8] == NEXT_FUNC; endproperty
	a_ctl_fn: assert property (p_ctl_fn) else $error("next function wrong");
	property p_srv_id; s_rd(SRIOV_HDR_OFS) |-> prdata[19:0] == {CAP_VERSION, SRIOV_CAP_ID}; endproperty
	a_srv_id: assert property (p_srv_id) else $error("sriov id wrong");
	property p_srv_ptr; s_rd(SRIOV_HDR_OFS) |-> prdata[31:20] == EXP; endproperty
	a_srv_ptr: assert property (p_srv_ptr) else $error("sriov pointer wrong");
	property p_srv_pos; s_rd(SRIOV_HDR_OFS) |-> prdata[31:20] == next_cap_ptr; endproperty
	a_srv_pos: assert property (p_srv_pos) else $error("sriov pointer field misplaced");
	property p_ptr_out; $past(rst_b) |-> next_cap_ptr == EXP; endproperty
	a_ptr_out: assert property (p_ptr_out) else $error("pointer output wrong");
	property p_wr_ro;
		psel && penable && pwrite && (paddr == ARI_HDR_OFS || paddr == SRIOV_HDR_OFS) |-> pready && !pslverr;
	endproperty
	a_wr_ro: assert property (p_wr_ro) else $error("header write refused");
	property p_sec; next_cap_ptr == PTR_SEC_PCIE |-> PF_INDEX == 0 && LINK_GEN == 3 && VF_COUNT == 0; endproperty
	a_sec: assert property (p_sec) else $error("secondary pointer in wrong build");
	c_ari: cover property (s_rd(ARI_HDR_OFS));
	c_wr: cover property (psel && penable && pwrite && paddr == ARI_HDR_OFS);
	c_err: cover property (psel && penable && pslverr);
endmodule : cap_hdr_checker

bind cap_hdr_bank cap_hdr_checker #(.LINK_GEN(LINK_GEN), .HAS_TPH(HAS_TPH), .HAS_ATS(HAS_ATS),
	.VF_COUNT(VF_COUNT), .PF_INDEX(PF_INDEX), .NEXT_FUNC(NEXT_FUNC)) cap_hdr_checker_i (.clock, .rst_b,
	.paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .next_cap_ptr);

// ### bench/cfg_host.sv
`timescale 1ns/10ps
//--------
// Configuration requester on APB
//--------
module cfg_host #(
	parameter int N = 8
) (
	// Clock
	input wire logic clock,
	// Request
	output logic [11:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// Answer
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] rd [N]
);
	logic [31:0] rd_q [N];
	logic err_q;
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// Setup, access until ready, then release with inverted address and data
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= {4{w}};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd_q = rd;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : cfg_host

// ### bench/cap_hdr_bank_tb.sv
`timescale 1ns/10ps
//--------
// Header bank testbench
//--------
module cap_hdr_bank_tb;
	import cap_hdr_pkg::*;
	localparam int N = 8;
	// Rows: build settings beside the pointer they select
	localparam int GEN [N] = '{3, 2, 1, 3, 3, 1, 1, 2};
	localparam bit TPH [N] = '{0, 1, 0, 1, 1, 0, 0, 0};
	localparam bit ATS [N] = '{0, 1, 1, 0, 1, 1, 0, 0};
	localparam int VFS [N] = '{0, 0, 0, 4, 0, 0, 0, 0};
	localparam int PFI [N] = '{0, 0, 0, 0, 1, 2, 3, 0};
	localparam logic [11:0] EPTR [N] = '{12'h280, 12'h300, 12'h3c0, 12'h200, 12'h300, 12'h3c0, 12'h000, 12'h000};
	localparam logic [7:0] NXF [N] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01};
	localparam logic [11:0] RO_OFS [3] = '{ARI_HDR_OFS, ARI_CTRL_OFS, SRIOV_HDR_OFS};
	logic clock;
	logic rst_b;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata_w [N];
	logic pready_w [N];
	logic pslverr_w [N];
	logic [11:0] ptr_w [N];
	int err_total = 0;
	int n_compared = 0;
	// Clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// One bank per row, sharing the bus
	for (genvar i = 0; i < N; i++) begin : g
		cap_hdr_bank #(.LINK_GEN(GEN[i]), .HAS_TPH(TPH[i]), .HAS_ATS(ATS[i]), .VF_COUNT(VFS[i]), .PF_INDEX(PFI[i]),
			.NEXT_FUNC(NXF[i]))
			cap_hdr_bank_i (.clock, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata(prdata_w[i]),
			.pready(pready_w[i]), .pslverr(pslverr_w[i]), .next_cap_ptr(ptr_w[i]));
	end
	cfg_host #(.N(N)) cfg_host_i (.clock, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.pready(pready_w[0]), .pslverr(pslverr_w[0]), .rd(prdata_w));
	function automatic logic [31:0] exp_word(input logic [11:0] o, input int i);
		if (o == ARI_CTRL_OFS) return {16'h0000, NXF[i], 8'h00};
		return {EPTR[i], CAP_VERSION, (o == ARI_HDR_OFS) ? ARI_CAP_ID : SRIOV_CAP_ID};
	endfunction : exp_word
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk_word
	task automatic chk_bit(input string nm, input logic e, input logic s);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %b seen %b", nm, e, s);
		end
	endtask : chk_bit
	// Read the three words from every row, and the pointer outputs
	task automatic check_all();
		for (int k = 0; k < 3; k++) begin
			cfg_host_i.xfer(RO_OFS[k], 1'b0, 32'h0);
			for (int i = 0; i < N; i++) chk_word("word", exp_word(RO_OFS[k], i), cfg_host_i.rd_q[i]);
		end
		for (int i = 0; i < N; i++) chk_word("ptr", {20'h0, EPTR[i]}, {20'h0, ptr_w[i]});
	endtask : check_all
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	// Watchdog
	initial begin
		#8000;
		err_total++;
		final_report();
	end
	// Main sequence
	initial begin
		rst_b = 1'b0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		check_all();
		$display("row test done");
		for (int k = 0; k < 3; k++) begin
			cfg_host_i.xfer(RO_OFS[k], 1'b1, 32'hffff_ffff);
			chk_bit("wr_err", 1'b0, cfg_host_i.err_q);
		end
		check_all();
		cfg_host_i.xfer(BANK_STAT_OFS, 1'b0, 32'h0);
		chk_bit("dropped", 1'b1, cfg_host_i.rd_q[0][DROP_FLAG_BIT]);
		chk_word("stat_ptr", {20'h0, EPTR[0]}, {20'h0, cfg_host_i.rd_q[0][11:0]});
		cfg_host_i.xfer(BANK_CTRL_OFS, 1'b1, 32'h2);
		cfg_host_i.xfer(BANK_STAT_OFS, 1'b0, 32'h0);
		chk_bit("drop_clr", 1'b0, cfg_host_i.rd_q[0][DROP_FLAG_BIT]);
		$display("write test done");
		cfg_host_i.xfer(12'h100, 1'b0, 32'h0);
		chk_word("unmapped", 32'h0, cfg_host_i.rd_q[0]);
		chk_bit("unm_err", 1'b0, cfg_host_i.err_q);
		cfg_host_i.xfer(BANK_CTRL_OFS, 1'b1, 32'h1);
		cfg_host_i.xfer(12'h100, 1'b0, 32'h0);
		chk_bit("unm_err", 1'b1, cfg_host_i.err_q);
		cfg_host_i.xfer(BANK_CTRL_OFS, 1'b0, 32'h0);
		chk_word("ctrl_rd", 32'h1, cfg_host_i.rd_q[0]);
		$display("unmapped test done");
		@(posedge clock);
		rst_b <= 1'b0;
		@(posedge clock);
		#1 chk_word("ptr_rst", 32'h0, {20'h0, ptr_w[0]});
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		check_all();
		cfg_host_i.xfer(12'h100, 1'b0, 32'h0);
		chk_bit("rst_err", 1'b0, cfg_host_i.err_q);
		$display("reset test done");
		final_report();
	end
endmodule : cap_hdr_bank_tb
